// file: dv/acc_conversion_control_monitor.sv
`timescale 1ns/1ps
module acc_conversion_control_monitor
  import acc_pkg::*;
#(
  parameter int ACQ_BASE = 1
) (
  input  wire logic               ref_clk_i,
  input  wire logic               srst_i,
  input  wire logic [7:0]         sfr_addr_i,
  input  wire logic               sfr_wr_i,
  input  wire logic [7:0]         sfr_wdata_i,
  input  wire logic               irq_vector_i,
  input  wire logic               converter_interrupt_flag_o,
  input  wire logic [3:0]         mux_select_o,
  input  wire logic               track_hold_o,
  input  wire logic               sar_active_o,
  input  wire logic               ref_power_o,
  input  wire logic               core_power_o,
  input  wire logic               conv_clk_en_o,
  input  wire logic               tbl_rd_o,
  input  wire logic               tbl_valid_i,
  input  wire logic [3:0]         tbl_channel_i,
  input  wire logic               mem_wr_valid_o,
  input  wire logic               mem_wr_ready_i,
  input  wire acc_pkg::acc_word_s mem_wr_o
);
  import acc_pkg::*;
  // ----------------------------------------------------------------
  // shadow of the config register and phase length counters
  // ----------------------------------------------------------------
  logic [7:0] cfg;
  logic [7:0] acq_n;
  logic [7:0] sar_n;
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) cfg <= RST_CONFIG;
    else if (sfr_wr_i && sfr_addr_i == ADDR_CONFIG) cfg <= sfr_wdata_i;
  end
  always_ff @(posedge ref_clk_i) begin
    acq_n <= track_hold_o ? acq_n + 8'h01 : 8'h00;
    sar_n <= sar_active_o ? sar_n + 8'h01 : 8'h00;
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  sequence s_stop_quiet;
    (converter_interrupt_flag_o && !tbl_rd_o) [*3];
  endsequence
  a_conv_length: assert property (
    $fell(sar_active_o) |-> sar_n == (8'h10 << cfg[5:4])) else $error("conversion length wrong");
  a_acq_length: assert property (
    $fell(track_hold_o) |-> acq_n == ((8'(ACQ_BASE) + 8'(cfg[3:2])) << cfg[5:4])) else $error("acquire length wrong");
  a_acq_to_conv: assert property (
    $fell(track_hold_o) |-> sar_active_o) else $error("conversion did not follow acquisition");
  a_tick_rate: assert property (
    sar_active_o && conv_clk_en_o && cfg[5:4] == 2'h3 |=> !conv_clk_en_o [*7]) else $error("divide by 8 wrong");
  a_mux_hold: assert property (
    sar_active_o && $past(sar_active_o) |-> $stable(mux_select_o)) else $error("channel moved in conversion");
  a_power_normal: assert property (
    cfg[7:6] == MODE_NORMAL |-> core_power_o && ref_power_o) else $error("normal mode not powered");
  a_power_off: assert property (
    cfg[7:6] == MODE_OFF && !track_hold_o && !sar_active_o |-> !core_power_o && !ref_power_o)
    else $error("power down not off");
  a_standby_ref: assert property (
    cfg[7:6] == MODE_STBY_IDLE && !track_hold_o && !sar_active_o |-> ref_power_o && !core_power_o)
    else $error("standby power wrong");
  a_power_busy: assert property (
    (track_hold_o || sar_active_o) && cfg[7:6] != MODE_OFF |-> core_power_o && ref_power_o)
    else $error("converter unpowered while converting");
  a_buf_hold: assert property (
    mem_wr_valid_o && !mem_wr_ready_i |=> mem_wr_valid_o && $stable(mem_wr_o)) else $error("stalled word lost");
  a_flag_clear: assert property (
    irq_vector_i && !sar_active_o && !track_hold_o && !tbl_valid_i |=> !converter_interrupt_flag_o)
    else $error("flag not cleared by vector");
  a_capture_stop: assert property (
    tbl_rd_o && tbl_valid_i && tbl_channel_i == CHAN_STOP |=> s_stop_quiet) else $error("stop marker ignored");
endmodule : acc_conversion_control_monitor

bind acc_conversion_control acc_conversion_control_monitor #(.ACQ_BASE(ACQ_BASE)) mon_u (
  .ref_clk_i, .srst_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i, .irq_vector_i, .converter_interrupt_flag_o,
  .mux_select_o, .track_hold_o, .sar_active_o, .ref_power_o, .core_power_o, .conv_clk_en_o, .tbl_rd_o,
  .tbl_valid_i, .tbl_channel_i, .mem_wr_valid_o, .mem_wr_ready_i, .mem_wr_o);

// file: dv/acc_mem_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// external data memory holding the capture table
// ----------------------------------------------------------------
module acc_mem_model
  import acc_pkg::*;
(
  input  wire logic                 ref_clk_i,
  input  wire logic                 stall_i,
  input  wire logic                 tbl_rd_i,
  input  wire logic [ADDR_BITS-1:0] tbl_addr_i,
  output      logic                 tbl_valid_o,
  output      logic [3:0]           tbl_channel_o,
  input  wire logic                 mem_valid_i,
  output      logic                 mem_ready_o,
  input  wire acc_pkg::acc_word_s   mem_word_i
);
  import acc_pkg::*;
  logic [15:0] mem [0:255];
  assign mem_ready_o = !stall_i;
  always @(posedge ref_clk_i) begin
    tbl_valid_o <= tbl_rd_i && !tbl_valid_o;
    // channel lines toggle outside an answer so no stale value is seen
    tbl_channel_o <= tbl_valid_o ? ~tbl_channel_o : mem[tbl_addr_i[7:0]][15:12];
    if (mem_valid_i && mem_ready_o) mem[mem_word_i.addr[7:0]] <= mem_word_i.data;
  end
endmodule : acc_mem_model

// file: dv/testbench.sv
`timescale 1ns/1ps
module testbench;
  import acc_pkg::*;
  localparam logic [15:0] CAL_OFF  = 16'h0123; // arbitrary
  localparam logic [15:0] CAL_GAIN = 16'h4567; // arbitrary
  logic                 ref_clk_i, srst_i, sfr_wr_i, irq_vector_i, timer2_overflow_i, cal_wr_i, stall;
  logic                 convert_start_pin_n_i, converter_interrupt_flag_o, track_hold_o, sar_active_o;
  logic                 ref_power_o, core_power_o, conv_clk_en_o, tbl_rd_o, tbl_valid_i;
  logic                 mem_wr_valid_o, mem_wr_ready_i;
  logic [7:0]           sfr_addr_i, sfr_wdata_i, sfr_rdata_o;
  logic [3:0]           mux_select_o, tbl_channel_i;
  logic [11:0]          sar_result_i;
  logic [15:0]          cal_offset_i, cal_gain_i, cal_offset_o, cal_gain_o;
  logic [ADDR_BITS-1:0] capture_start_i, tbl_addr_o;
  acc_word_s            mem_wr_o;
  int                   fail_count, comparisons, n;
  acc_conversion_control #(.ACQ_BASE(1), .CAL_OFFSET_DEFAULT(CAL_OFF), .CAL_GAIN_DEFAULT(CAL_GAIN)) dut_u (
    .ref_clk_i, .srst_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i, .sfr_rdata_o, .irq_vector_i,
    .converter_interrupt_flag_o, .timer2_overflow_i, .convert_start_pin_n_i, .mux_select_o, .track_hold_o,
    .sar_active_o, .ref_power_o, .core_power_o, .conv_clk_en_o, .sar_result_i, .cal_wr_i, .cal_offset_i,
    .cal_gain_i, .cal_offset_o, .cal_gain_o, .capture_start_i, .tbl_rd_o, .tbl_addr_o, .tbl_valid_i,
    .tbl_channel_i, .mem_wr_valid_o, .mem_wr_ready_i, .mem_wr_o);
  acc_mem_model mem_u (.ref_clk_i, .stall_i(stall), .tbl_rd_i(tbl_rd_o), .tbl_addr_i(tbl_addr_o),
    .tbl_valid_o(tbl_valid_i), .tbl_channel_o(tbl_channel_i), .mem_valid_i(mem_wr_valid_o),
    .mem_ready_o(mem_wr_ready_i), .mem_word_i(mem_wr_o));
  // ----------------------------------------------------------------
  // shared bus and compare tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic vec();
    irq_vector_i <= 1'b1;
    @(posedge ref_clk_i);
    irq_vector_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask : vec
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr_i  <= a;
    sfr_wdata_i <= d;
    sfr_wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    sfr_wr_i    <= 1'b0;
    @(posedge ref_clk_i);
  endtask : wr
  task automatic rd(input string what, input logic [7:0] a, input logic [7:0] exp);
    sfr_addr_i <= a;
    @(posedge ref_clk_i);
    check(what, sfr_rdata_o, exp);
  endtask : rd
  task automatic wait_flag();
    for (int i = 0; i < 600 && converter_interrupt_flag_o !== 1'b1; i++) @(posedge ref_clk_i);
    check("flag", converter_interrupt_flag_o, 1'b1);
  endtask : wait_flag
  task automatic count_conv();
    logic p;
    n = 0;
    p = sar_active_o;
    repeat (80) begin
      @(posedge ref_clk_i);
      n += int'(sar_active_o && !p);
      p = sar_active_o;
    end
  endtask : count_conv
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rd("chan ctrl reset", ADDR_CHANNEL_CONTROL, RST_CHANNEL_CONTROL);
    rd("config reset", ADDR_CONFIG, RST_CONFIG);
    wr(8'hF5, 8'hFF);
    rd("unmapped", 8'hF5, 8'h00);
    check("cal offset", cal_offset_o, CAL_OFF);
    check("cal gain", cal_gain_o, CAL_GAIN);
    cal_offset_i <= 16'hBEEF;
    cal_gain_i <= 16'h1357;
    cal_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    cal_wr_i <= 1'b0;
    @(posedge ref_clk_i);
    check("cal offset wr", cal_offset_o, 16'hBEEF);
    check("cal gain wr", cal_gain_o, 16'h1357);
    $display("test regs done");
  endtask : t_regs
  task automatic t_power();
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_CONFIG, {m[1:0], 6'h00});
      check("core power", core_power_o, m == 1);
      check("ref power", ref_power_o, m == 1 || m == 3);
    end
    $display("test power done");
  endtask : t_power
  task automatic t_single();
    logic [3:0] ch;
    for (int i = 0; i < 4; i++) begin
      ch = (i == 3) ? CHAN_TEMP : 4'(2 * i + 1);
      wr(ADDR_CONFIG, {(i < 2) ? 2'h1 : i[1:0], i[1:0], i[1:0], 2'h0});
      wr(ADDR_CHANNEL_CONTROL, {4'h1, ch});
      wait_flag();
      check("mux", mux_select_o, ch);
      rd("single cleared", ADDR_CHANNEL_CONTROL, {4'h8, ch});
      vec();
      rd("flag cleared", ADDR_CHANNEL_CONTROL, {4'h0, ch});
    end
    $display("test single done");
  endtask : t_single
  task automatic t_trig();
    for (int k = 0; k < 3; k++) begin
      wr(ADDR_CONFIG, k == 0 ? 8'h42 : k == 1 ? 8'h41 : 8'h40);
      if (k == 0) timer2_overflow_i <= 1'b1;
      else convert_start_pin_n_i <= 1'b0;
      repeat (k == 0 ? 1 : 25) @(posedge ref_clk_i);
      timer2_overflow_i <= 1'b0;
      convert_start_pin_n_i <= 1'b1;
      repeat (60) @(posedge ref_clk_i);
      check("trigger flag", converter_interrupt_flag_o, k < 2);
      vec();
    end
    $display("test trig done");
  endtask : t_trig
  task automatic t_cont();
    wr(ADDR_CHANNEL_CONTROL, 8'h23);
    count_conv();
    check("cont runs", n >= 3, 1'b1);
    wr(ADDR_CHANNEL_CONTROL, 8'h03);
    repeat (30) @(posedge ref_clk_i);
    count_conv();
    check("cont stopped", n, 0);
    vec();
    $display("test cont done");
  endtask : t_cont
  task automatic t_capture();
    logic [3:0] chs [3];
    chs = '{4'h2, 4'h8, 4'h5};
    mem_u.mem[16] = 16'h2000;
    mem_u.mem[17] = 16'h8000;
    mem_u.mem[18] = 16'h5000;
    mem_u.mem[19] = 16'hF000;
    stall <= 1'b1;
    wr(ADDR_CHANNEL_CONTROL, 8'h40);
    repeat (100) @(posedge ref_clk_i);
    check("held word", mem_wr_valid_o, 1'b1);
    check("no write in stall", mem_u.mem[16], 16'h2000);
    stall <= 1'b0;
    wait_flag();
    for (int j = 0; j < 3; j++) check("stored word", mem_u.mem[16 + j], {chs[j], 12'hA5C});
    check("stop kept", mem_u.mem[19], 16'hF000);
    rd("capture cleared", ADDR_CHANNEL_CONTROL, 8'h80);
    $display("test capture done");
  endtask : t_capture
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    fail_count++;
    give_verdict();
  end
  initial begin
    {srst_i, sfr_wr_i, irq_vector_i, timer2_overflow_i, cal_wr_i, stall} = 6'h20;
    convert_start_pin_n_i = 1'b1;
    {sfr_addr_i, sfr_wdata_i, cal_offset_i, cal_gain_i} = '0;
    sar_result_i = 12'hA5C;
    capture_start_i = 24'h000010;
    repeat (16) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    @(posedge ref_clk_i);
    t_regs();
    t_power();
    t_single();
    t_trig();
    t_cont();
    t_capture();
    give_verdict();
  end
endmodule : testbench

// file: src/acc_buf2.sv
`timescale 1ns/1ps
module acc_buf2 #(
  parameter int WIDTH = 40
) (
  input  wire logic             ref_clk_i,
  input  wire logic             srst_i,
  input  wire logic             in_valid_i,
  output      logic             in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output      logic             out_valid_o,
  input  wire logic             out_ready_i,
  output      logic [WIDTH-1:0] out_data_o
);
  if (WIDTH < 1) begin : g_width_check
    $error("acc_buf2: WIDTH must be positive");
  end

  logic [WIDTH-1:0] mem [2];
  logic             wr_ptr;
  logic             rd_ptr;
  logic [1:0]       count;
  wire              push = in_valid_i && in_ready_o;
  wire              pop  = out_valid_o && out_ready_i;

  assign in_ready_o  = (count != 2'h2);
  assign out_valid_o = (count != 2'h0);
  assign out_data_o  = mem[rd_ptr];

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end else begin
      if (push) wr_ptr <= ~wr_ptr;
      if (pop) rd_ptr <= ~rd_ptr;
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (push) mem[wr_ptr] <= in_data_i;
  end
endmodule : acc_buf2

// file: src/acc_conversion_control.sv
`timescale 1ns/1ps
module acc_conversion_control
  import acc_pkg::*;
#(
  parameter int                      ACQ_BASE = 1,
  parameter logic [15:0]             CAL_OFFSET_DEFAULT = 16'h0000, // arbitrary
  parameter logic [15:0]             CAL_GAIN_DEFAULT   = 16'h8000  // arbitrary
) (
  input  wire logic                  ref_clk_i,
  input  wire logic                  srst_i,
  // special function register port
  input  wire logic [7:0]            sfr_addr_i,
  input  wire logic                  sfr_wr_i,
  input  wire logic [7:0]            sfr_wdata_i,
  output      logic [7:0]            sfr_rdata_o,
  input  wire logic                  irq_vector_i,
  output      logic                  converter_interrupt_flag_o,
  // triggers
  input  wire logic                  timer2_overflow_i,
  input  wire logic                  convert_start_pin_n_i,
  // analog front end
  output      logic [3:0]            mux_select_o,
  output      logic                  track_hold_o,
  output      logic                  sar_active_o,
  output      logic                  ref_power_o,
  output      logic                  core_power_o,
  output      logic                  conv_clk_en_o,
  input  wire logic [11:0]           sar_result_i,
  // calibration
  input  wire logic                  cal_wr_i,
  input  wire logic [15:0]           cal_offset_i,
  input  wire logic [15:0]           cal_gain_i,
  output      logic [15:0]           cal_offset_o,
  output      logic [15:0]           cal_gain_o,
  // capture memory access
  input  wire logic [acc_pkg::ADDR_BITS-1:0] capture_start_i,
  output      logic                  tbl_rd_o,
  output      logic [acc_pkg::ADDR_BITS-1:0] tbl_addr_o,
  input  wire logic                  tbl_valid_i,
  input  wire logic [3:0]            tbl_channel_i,
  output      logic                  mem_wr_valid_o,
  input  wire logic                  mem_wr_ready_i,
  output      acc_pkg::acc_word_s    mem_wr_o
);
  import acc_pkg::*;

  // acquisition counter is five bits wide
  if (ACQ_BASE < 1 || ACQ_BASE > 28) begin : g_acq_check
    $error("acc_conversion_control: ACQ_BASE must lie in 1 to 28");
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0]           cfg;
  logic                 flag;
  logic                 capture_en;
  logic                 cont;
  logic                 single;
  logic [3:0]           chan;
  logic [15:0]          cal_offset;
  logic [15:0]          cal_gain;
  acc_state_e           state;
  logic [3:0]           div_cnt;
  logic [4:0]           cyc_cnt;
  logic [3:0]           conv_chan;
  logic [ADDR_BITS-1:0] ptr;
  logic                 pin_q;

  // ----------------------------------------------------------------
  // decoding
  // ----------------------------------------------------------------
  wire [1:0] mode      = cfg[CFG_MODE_HI:CFG_MODE_LO];
  wire [1:0] div_sel   = cfg[CFG_DIV_HI:CFG_DIV_LO];
  wire [1:0] acq_sel   = cfg[CFG_ACQ_HI:CFG_ACQ_LO];
  wire       wr_cfg    = sfr_wr_i && (sfr_addr_i == ADDR_CONFIG);
  wire       wr_cc     = sfr_wr_i && (sfr_addr_i == ADDR_CHANNEL_CONTROL);
  wire [3:0] div_lim   = 4'((4'h1 << div_sel) - 4'h1);
  wire       tick      = (div_cnt == div_lim);
  wire [4:0] acq_len   = 5'(ACQ_BASE) + {3'h0, acq_sel};
  wire       pin_rise  = convert_start_pin_n_i && !pin_q;
  wire       ext_trig  = cfg[CFG_EXT_EN] && pin_rise;
  wire       tmr_trig  = cfg[CFG_TIMER_EN] && timer2_overflow_i;
  wire       powered   = (mode != MODE_OFF);
  wire       busy      = (state != ACC_IDLE);
  wire       buf_ready;
  wire       conv_done = (state == ACC_CONV) && tick && (cyc_cnt == 5'(CONV_CLOCKS - 1));
  wire       sw_start  = single || cont;
  wire       start     = powered && (sw_start || tmr_trig || ext_trig) && !capture_en;
  wire       tbl_stop  = tbl_valid_i && (tbl_channel_i == CHAN_STOP);
  wire       cap_done  = (state == ACC_FETCH) && tbl_stop;
  wire       cap_arm   = wr_cc && sfr_wdata_i[CC_CAPTURE] && powered;
  // a capture entry is taken only with room in the buffer, so a conversion never stalls
  wire       fetch_go  = (state == ACC_FETCH) && tbl_valid_i && !tbl_stop && buf_ready;
  wire       idle_go   = (state == ACC_IDLE) && !cap_arm && start;
  // converter clock restarts at each new acquisition so every phase spans whole ticks
  wire       conv_go   = idle_go || fetch_go;
  wire       vec_clr   = irq_vector_i && flag;
  wire       set_flag  = (conv_done && !capture_en) || cap_done;
  wire       wr_single = wr_cc && sfr_wdata_i[CC_SINGLE];

  assign sfr_rdata_o = (sfr_addr_i == ADDR_CONFIG) ? cfg :
                       (sfr_addr_i == ADDR_CHANNEL_CONTROL) ? {flag, capture_en, cont, single, chan} :
                       8'h00;

  // ----------------------------------------------------------------
  // configuration and channel control
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      cfg        <= RST_CONFIG;
      flag       <= RST_CHANNEL_CONTROL[CC_FLAG];
      capture_en <= RST_CHANNEL_CONTROL[CC_CAPTURE];
      cont       <= RST_CHANNEL_CONTROL[CC_CONT];
      single     <= RST_CHANNEL_CONTROL[CC_SINGLE];
      chan       <= RST_CHANNEL_CONTROL[3:0];
    end else begin
      if (wr_cfg) cfg <= sfr_wdata_i;
      if (set_flag) flag <= 1'b1;
      else if (vec_clr) flag <= 1'b0;
      else if (wr_cc) flag <= sfr_wdata_i[CC_FLAG];
      if (cap_done) capture_en <= 1'b0;
      else if (wr_cc) capture_en <= sfr_wdata_i[CC_CAPTURE];
      if (wr_cc) cont <= sfr_wdata_i[CC_CONT];
      if (wr_single) single <= 1'b1;
      else if (conv_done && !capture_en) single <= 1'b0;
      else if (wr_cc) single <= 1'b0;
      if (wr_cc) chan <= sfr_wdata_i[3:0];
    end
  end

  // ----------------------------------------------------------------
  // calibration registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      cal_offset <= CAL_OFFSET_DEFAULT;
      cal_gain   <= CAL_GAIN_DEFAULT;
    end else if (cal_wr_i) begin
      cal_offset <= cal_offset_i;
      cal_gain   <= cal_gain_i;
    end
  end
  assign cal_offset_o = cal_offset;
  assign cal_gain_o   = cal_gain;

  // ----------------------------------------------------------------
  // clock divider and trigger edge
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      div_cnt <= 4'h0;
      pin_q   <= 1'b1;
    end else begin
      pin_q   <= convert_start_pin_n_i;
      div_cnt <= (tick || conv_go) ? 4'h0 : 4'(div_cnt + 4'h1);
    end
  end

  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      state     <= ACC_IDLE;
      cyc_cnt   <= 5'h00;
      conv_chan <= 4'h0;
      ptr       <= '0;
    end else begin
      case (state)
        ACC_IDLE: begin
          cyc_cnt <= 5'h00;
          if (cap_arm) begin
            ptr   <= capture_start_i;
            state <= ACC_FETCH;
          end else if (start) begin
            conv_chan <= chan;
            state     <= ACC_ACQ;
          end
        end
        ACC_FETCH: begin
          if (tbl_stop) state <= ACC_IDLE;
          else if (fetch_go) begin
            conv_chan <= tbl_channel_i;
            state     <= ACC_ACQ;
          end
        end
        ACC_ACQ: begin
          if (tick) begin
            if (cyc_cnt == acq_len - 5'h01) begin
              cyc_cnt <= 5'h00;
              state   <= ACC_CONV;
            end else cyc_cnt <= cyc_cnt + 5'h01;
          end
        end
        ACC_CONV: begin
          if (conv_done) begin
            cyc_cnt <= 5'h00;
            if (capture_en) begin
              ptr   <= ptr + 24'h000001;
              state <= ACC_FETCH;
            end else if (cont && !wr_cc) begin
              conv_chan <= chan;
              state     <= ACC_ACQ;
            end else state <= ACC_IDLE;
          end else if (tick && cyc_cnt != 5'(CONV_CLOCKS - 1)) cyc_cnt <= cyc_cnt + 5'h01;
        end
        default: state <= ACC_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // analog controls
  // ----------------------------------------------------------------
  assign mux_select_o  = conv_chan;
  assign track_hold_o  = (state == ACC_ACQ);
  assign sar_active_o  = (state == ACC_CONV);
  assign core_power_o  = (mode == MODE_NORMAL) || (powered && busy);
  assign ref_power_o   = (mode == MODE_NORMAL) || (mode == MODE_STBY_IDLE) || busy;
  assign conv_clk_en_o = tick && busy;
  assign converter_interrupt_flag_o = flag;
  assign tbl_rd_o      = (state == ACC_FETCH);
  assign tbl_addr_o    = ptr;

  // ----------------------------------------------------------------
  // result buffer toward memory
  // ----------------------------------------------------------------
  acc_word_s buf_in;
  assign buf_in.addr = ptr;
  assign buf_in.data = {conv_chan, sar_result_i};
  wire       buf_push = conv_done && capture_en;

  acc_buf2 #(
    .WIDTH ($bits(acc_word_s))
  ) u_buf (
    .ref_clk_i   (ref_clk_i),
    .srst_i      (srst_i),
    .in_valid_i  (buf_push),
    .in_ready_o  (buf_ready),
    .in_data_i   (buf_in),
    .out_valid_o (mem_wr_valid_o),
    .out_ready_i (mem_wr_ready_i),
    .out_data_o  (mem_wr_o)
  );

endmodule : acc_conversion_control

// file: src/acc_pkg.sv
package acc_pkg;

  // ----------------------------------------------------------------
  // register addresses and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CHANNEL_CONTROL = 8'hD8;
  localparam logic [7:0] ADDR_CONFIG          = 8'hEF;
  localparam logic [7:0] RST_CHANNEL_CONTROL  = 8'h00;
  localparam logic [7:0] RST_CONFIG           = 8'h20;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CFG_MODE_HI  = 7;
  localparam int CFG_MODE_LO  = 6;
  localparam int CFG_DIV_HI   = 5;
  localparam int CFG_DIV_LO   = 4;
  localparam int CFG_ACQ_HI   = 3;
  localparam int CFG_ACQ_LO   = 2;
  localparam int CFG_TIMER_EN = 1;
  localparam int CFG_EXT_EN   = 0;
  localparam int CC_FLAG      = 7;
  localparam int CC_CAPTURE   = 6;
  localparam int CC_CONT      = 5;
  localparam int CC_SINGLE    = 4;

  // ----------------------------------------------------------------
  // timing and encodings
  // ----------------------------------------------------------------
  localparam int        CONV_CLOCKS   = 16;
  localparam int        RESULT_BITS   = 12;
  localparam logic [3:0] CHAN_STOP    = 4'hF;
  localparam logic [3:0] CHAN_TEMP    = 4'h8;
  localparam logic [1:0] MODE_OFF     = 2'h0;
  localparam logic [1:0] MODE_NORMAL  = 2'h1;
  localparam logic [1:0] MODE_OFF_IDLE = 2'h2;
  localparam logic [1:0] MODE_STBY_IDLE = 2'h3;
  localparam int        ADDR_BITS     = 24;

  typedef enum logic [1:0] {ACC_IDLE, ACC_FETCH, ACC_ACQ, ACC_CONV} acc_state_e;

  typedef struct packed {
    logic [ADDR_BITS-1:0] addr;
    logic [15:0]          data;
  } acc_word_s;

endpackage : acc_pkg
